/* File: src/maker_cmd_pkg.sv */
package maker_cmd_pkg;

  // Register offsets (word index of the command word and the two thresholds)
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_CHARGE_THR = 8'h01;
  localparam logic [7:0] REG_TIME_THR = 8'h02;

  // Command codes written to the maker command word
  localparam logic [15:0] CODE_STORAGE = 16'h0618;
  localparam logic [15:0] CODE_SEAL = 16'h062B;
  localparam logic [15:0] CODE_CHARGE_SYNC = 16'h064D;
  localparam logic [15:0] CODE_CAL_STD = 16'h0653;
  localparam logic [15:0] CODE_CAL_ALT = 16'h067E;
  localparam logic [15:0] CODE_CAL_STOP = 16'h0660;
  localparam logic [15:0] CODE_EE_PROG = 16'h0606;
  localparam logic [15:0] CODE_NONE = 16'h0000;

  // Battery address byte that ends pass-through
  localparam logic [7:0] BATTERY_ADDR = 8'h16;

  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_NS = 1000000;
  localparam int TICK_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BOOT_IGNORE_MS = 1000;
  localparam int STORE_DELAY_MS = 6000;
  localparam int STORE_AFTER_CAL_MS = 20000;
  localparam int CAL_START_MS = 100;
  localparam int CAL_CAP_MS = 3600000;

  localparam int PCT_FULL = 100;

  // Reset values
  localparam logic [15:0] THR_RST = 16'h0000;
  localparam logic OFFSET_CORR_RST = 1'b1;

  typedef enum {CAL_IDLE, CAL_WAIT, CAL_RUN, CAL_SAVE} cal_state_t;
  typedef enum {ST_IDLE, ST_WAIT, ST_SLEEP} store_state_t;

endpackage : maker_cmd_pkg

/* File: src/tick_if.sv */
`timescale 1ns/1ps
interface tick_if;
  logic ms_tick;
  modport gen (output ms_tick);
  modport use_tick (input ms_tick);
endinterface : tick_if

/* File: src/ms_tick_gen.sv */
`timescale 1ns/1ps
module ms_tick_gen #(
  parameter int TICK_CYCLES = maker_cmd_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  tick_if.gen tick
);
  logic [31:0] div_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= 32'h00000000;
      tick.ms_tick <= 1'b0;
    end else if (div_ff == 32'(TICK_CYCLES - 1)) begin
      div_ff <= 32'h00000000;
      tick.ms_tick <= 1'b1;
    end else begin
      div_ff <= div_ff + 32'h00000001;
      tick.ms_tick <= 1'b0;
    end
  end
endmodule : ms_tick_gen

/* File: src/maker_command_and_alarm_thresholds.sv */
`timescale 1ns/1ps
// How it works
// - Command word writes during the first second after reset are dropped.
// - Storage command enters low-power storage after a 6 s wait; display untouched.
// - Other command words are still taken while storage entry is pending.
// - Storage command word is cleared at the next millisecond tick.
// - Calibration during storage wait postpones storage until calibration ends (saved or stopped), then 20 s.
// - Seal restricts access and clears the command word at the next tick.
// - Charge sync loads termination percent of full capacity, clears command word.
// - Standard calibration, unsealed only, disconnects sense inputs, chip offset only.
// - Alternate calibration, unsealed only, keeps sense inputs for chip plus board.
// - During calibration LEDs blank; only stop and seal are accepted.
// - Calibration ends by itself, saves to EEPROM, capped at one hour.
// - Calibration command word cleared next tick; calibration starts after 100 ms.
// - Stop aborts calibration at once, unless it is already saving to EEPROM, and disables offset correction.
// - EEPROM command, unsealed only, routes SMBus through, powers EEPROM, halts monitoring.
// - Battery address byte seen on SMBus ends pass-through.
// - Calibrated flag clears when calibration starts, sets when the EEPROM save completes, also after the one-hour cap.
// - Low-charge warning when charge left is below a nonzero threshold.
// - Charge threshold loads from EEPROM, then holds until host writes it.
// - Charge threshold is 16-bit unsigned, units follow the capacity unit select.
// - Low-time warning when mean time left is below a nonzero threshold.
// - Time threshold loads from EEPROM, then holds until host writes it.
module maker_command_and_alarm_thresholds #(
  parameter int TICK_CYCLES = maker_cmd_pkg::TICK_CYCLES,
  parameter int BOOT_IGNORE_MS = maker_cmd_pkg::BOOT_IGNORE_MS,
  parameter int STORE_DELAY_MS = maker_cmd_pkg::STORE_DELAY_MS,
  parameter int STORE_AFTER_CAL_MS = maker_cmd_pkg::STORE_AFTER_CAL_MS,
  parameter int CAL_START_MS = maker_cmd_pkg::CAL_START_MS,
  parameter int CAL_CAP_MS = maker_cmd_pkg::CAL_CAP_MS
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // Word access from the SMBus protocol engine
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [7:0] REQ_REG,
  input wire logic [15:0] REQ_WDATA,
  output logic RD_VALID,
  output logic [15:0] RD_DATA,
  // Address bytes observed on the SMBus
  input wire logic ADDR_SEEN,
  input wire logic [7:0] ADDR_BYTE,
  // EEPROM threshold load and calibration save
  input wire logic EE_LOAD_VALID,
  input wire logic [15:0] EE_CHARGE_THR,
  input wire logic [15:0] EE_TIME_THR,
  output logic EE_SAVE_REQ,
  input wire logic EE_SAVE_DONE,
  // Charge datapath
  input wire logic [15:0] CHARGE_LEFT,
  input wire logic [15:0] MEAN_TIME_LEFT,
  input wire logic [15:0] FULL_CAPACITY,
  input wire logic [7:0] TERM_PCT,
  input wire logic OFFSET_FOUND,
  output logic CHARGE_SYNC_STB,
  output logic [15:0] CHARGE_SYNC_VALUE,
  // Mode and control outputs
  output logic STORAGE_MODE,
  output logic SEALED,
  output logic LED_BLANK,
  output logic SENSE_DISCONNECT,
  output logic CAL_ACTIVE,
  output logic OFFSET_CORR_EN,
  output logic OFFSET_CAL_FLAG,
  output logic PASS_THRU,
  output logic EE_POWER,
  output logic MONITOR_HALT,
  // Alarm conditions for the broadcast engine
  output logic LOW_CHARGE_WARN,
  output logic LOW_TIME_WARN
);
  tick_if tick ();

  ms_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk(CLK),
    .rst_n(RSTN),
    .tick(tick.gen)
  );

  function automatic logic is_cal(input logic [15:0] code);
    is_cal = (code == maker_cmd_pkg::CODE_CAL_STD) || (code == maker_cmd_pkg::CODE_CAL_ALT);
  endfunction : is_cal

  maker_cmd_pkg::cal_state_t cal_state_ff;
  maker_cmd_pkg::store_state_t store_state_ff;
  logic [15:0] cmd_word_ff;
  logic [15:0] charge_thr_ff;
  logic [15:0] time_thr_ff;
  logic [15:0] boot_cnt_ff;
  logic boot_done_ff;
  logic clear_pend_ff;
  logic [31:0] store_cnt_ff;
  logic [31:0] cal_cnt_ff;
  logic cal_alt_ff;
  logic cal_busy;
  logic cmd_wr;
  logic cmd_take;
  logic [15:0] code;
  logic go_storage;
  logic go_seal;
  logic go_sync;
  logic go_cal;
  logic go_stop;
  logic go_ee;
  logic cal_end;
  localparam logic [15:0] THR_ZERO = maker_cmd_pkg::THR_RST;

  assign cal_busy = cal_state_ff != maker_cmd_pkg::CAL_IDLE;
  assign code = REQ_WDATA;
  assign cmd_wr = REQ_VALID && REQ_WRITE && (REQ_REG == maker_cmd_pkg::REG_CMD);
  // Early writes dropped; calibration admits only stop and seal
  assign cmd_take = cmd_wr && boot_done_ff &&
    (!cal_busy || code == maker_cmd_pkg::CODE_CAL_STOP || code == maker_cmd_pkg::CODE_SEAL);
  assign go_storage = cmd_take && code == maker_cmd_pkg::CODE_STORAGE;
  assign go_seal = cmd_take && code == maker_cmd_pkg::CODE_SEAL;
  assign go_sync = cmd_take && code == maker_cmd_pkg::CODE_CHARGE_SYNC;
  assign go_cal = cmd_take && is_cal(code) && !SEALED;
  assign go_stop = cmd_take && code == maker_cmd_pkg::CODE_CAL_STOP;
  assign go_ee = cmd_take && code == maker_cmd_pkg::CODE_EE_PROG && !SEALED && !PASS_THRU;
  assign cal_end = OFFSET_FOUND || (cal_cnt_ff == 32'(CAL_CAP_MS));

  // Power-up ignore window
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      boot_cnt_ff <= 16'h0000;
      boot_done_ff <= 1'b0;
    end else if (!boot_done_ff && tick.ms_tick) begin
      boot_cnt_ff <= boot_cnt_ff + 16'h0001;
      boot_done_ff <= (boot_cnt_ff == 16'(BOOT_IGNORE_MS - 1));
    end
  end

  // Command word: stored when taken, cleared at the next tick when acted on
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cmd_word_ff <= maker_cmd_pkg::CODE_NONE;
      clear_pend_ff <= 1'b0;
    end else if (cmd_take) begin
      cmd_word_ff <= code;
      // Undefined or refused codes just sit in the word
      clear_pend_ff <= go_storage || go_seal || go_sync || go_cal || go_stop || go_ee;
    end else if (clear_pend_ff && tick.ms_tick) begin
      cmd_word_ff <= maker_cmd_pkg::CODE_NONE;
      clear_pend_ff <= 1'b0;
    end
  end

  // Thresholds: EEPROM load gives the start value, host writes override
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      charge_thr_ff <= maker_cmd_pkg::THR_RST;
      time_thr_ff <= maker_cmd_pkg::THR_RST;
    end else begin
      if (REQ_VALID && REQ_WRITE && REQ_REG == maker_cmd_pkg::REG_CHARGE_THR) begin
        charge_thr_ff <= REQ_WDATA;
      end else if (EE_LOAD_VALID) begin
        charge_thr_ff <= EE_CHARGE_THR;
      end
      if (REQ_VALID && REQ_WRITE && REQ_REG == maker_cmd_pkg::REG_TIME_THR) begin
        time_thr_ff <= REQ_WDATA;
      end else if (EE_LOAD_VALID) begin
        time_thr_ff <= EE_TIME_THR;
      end
    end
  end

  // Read answer, one cycle after the request
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      RD_VALID <= 1'b0;
      RD_DATA <= 16'h0000;
    end else begin
      RD_VALID <= REQ_VALID && !REQ_WRITE;
      if (REQ_VALID && !REQ_WRITE) begin
        case (REQ_REG)
          maker_cmd_pkg::REG_CMD: RD_DATA <= cmd_word_ff;
          maker_cmd_pkg::REG_CHARGE_THR: RD_DATA <= charge_thr_ff;
          maker_cmd_pkg::REG_TIME_THR: RD_DATA <= time_thr_ff;
          default: RD_DATA <= 16'h0000;
        endcase
      end
    end
  end

  // Seal is sticky until reset
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      SEALED <= 1'b0;
    end else if (go_seal) begin
      SEALED <= 1'b1;
    end
  end

  // Charge synchronisation
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      CHARGE_SYNC_STB <= 1'b0;
      CHARGE_SYNC_VALUE <= 16'h0000;
    end else begin
      CHARGE_SYNC_STB <= go_sync;
      if (go_sync) begin
        CHARGE_SYNC_VALUE <= 16'((24'(FULL_CAPACITY) * 24'(TERM_PCT)) / 24'(maker_cmd_pkg::PCT_FULL));
      end
    end
  end

  // Calibration sequencer
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cal_state_ff <= maker_cmd_pkg::CAL_IDLE;
      cal_cnt_ff <= 32'h00000000;
      cal_alt_ff <= 1'b0;
    end else begin
      case (cal_state_ff)
        maker_cmd_pkg::CAL_IDLE: begin
          if (go_cal) begin
            cal_state_ff <= maker_cmd_pkg::CAL_WAIT;
            cal_cnt_ff <= 32'h00000000;
            cal_alt_ff <= (code == maker_cmd_pkg::CODE_CAL_ALT);
          end
        end
        maker_cmd_pkg::CAL_WAIT: begin
          if (go_stop) begin
            cal_state_ff <= maker_cmd_pkg::CAL_IDLE;
          end else if (tick.ms_tick) begin
            if (cal_cnt_ff == 32'(CAL_START_MS - 1)) begin
              cal_state_ff <= maker_cmd_pkg::CAL_RUN;
              cal_cnt_ff <= 32'h00000000;
            end else begin
              cal_cnt_ff <= cal_cnt_ff + 32'h00000001;
            end
          end
        end
        maker_cmd_pkg::CAL_RUN: begin
          if (go_stop) begin
            cal_state_ff <= maker_cmd_pkg::CAL_IDLE;
          end else if (cal_end) begin
            cal_state_ff <= maker_cmd_pkg::CAL_SAVE;
          end else if (tick.ms_tick) begin
            cal_cnt_ff <= cal_cnt_ff + 32'h00000001;
          end
        end
        maker_cmd_pkg::CAL_SAVE: begin
          if (EE_SAVE_DONE) begin
            cal_state_ff <= maker_cmd_pkg::CAL_IDLE;
          end
        end
        default: cal_state_ff <= maker_cmd_pkg::CAL_IDLE;
      endcase
    end
  end

  // Calibration-facing outputs, all registered
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      CAL_ACTIVE <= 1'b0;
      LED_BLANK <= 1'b0;
      SENSE_DISCONNECT <= 1'b0;
      EE_SAVE_REQ <= 1'b0;
    end else begin
      CAL_ACTIVE <= cal_state_ff == maker_cmd_pkg::CAL_RUN;
      LED_BLANK <= cal_busy;
      SENSE_DISCONNECT <= cal_state_ff == maker_cmd_pkg::CAL_RUN && !cal_alt_ff;
      EE_SAVE_REQ <= cal_state_ff == maker_cmd_pkg::CAL_SAVE && !EE_SAVE_DONE;
    end
  end

  // Offset correction and calibrated flag
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      OFFSET_CORR_EN <= maker_cmd_pkg::OFFSET_CORR_RST;
      OFFSET_CAL_FLAG <= 1'b0;
    end else if (go_stop && cal_busy) begin
      OFFSET_CORR_EN <= 1'b0;
    end else if (cal_state_ff == maker_cmd_pkg::CAL_WAIT && tick.ms_tick
                 && cal_cnt_ff == 32'(CAL_START_MS - 1)) begin
      OFFSET_CAL_FLAG <= 1'b0;
    end else if (cal_state_ff == maker_cmd_pkg::CAL_SAVE && EE_SAVE_DONE) begin
      OFFSET_CAL_FLAG <= 1'b1;
      OFFSET_CORR_EN <= 1'b1;
    end
  end

  // Storage entry; a running calibration holds the countdown at its reload value
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      store_state_ff <= maker_cmd_pkg::ST_IDLE;
      store_cnt_ff <= 32'h00000000;
      STORAGE_MODE <= 1'b0;
    end else begin
      case (store_state_ff)
        maker_cmd_pkg::ST_IDLE: begin
          if (go_storage) begin
            store_state_ff <= maker_cmd_pkg::ST_WAIT;
            store_cnt_ff <= 32'(STORE_DELAY_MS);
          end
        end
        maker_cmd_pkg::ST_WAIT: begin
          if (cal_busy) begin
            store_cnt_ff <= 32'(STORE_AFTER_CAL_MS);
          end else if (tick.ms_tick) begin
            if (store_cnt_ff == 32'h00000001) begin
              store_state_ff <= maker_cmd_pkg::ST_SLEEP;
              STORAGE_MODE <= 1'b1;
            end else begin
              store_cnt_ff <= store_cnt_ff - 32'h00000001;
            end
          end
        end
        maker_cmd_pkg::ST_SLEEP: STORAGE_MODE <= 1'b1;
        default: store_state_ff <= maker_cmd_pkg::ST_IDLE;
      endcase
    end
  end

  // EEPROM pass-through
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PASS_THRU <= 1'b0;
      EE_POWER <= 1'b0;
      MONITOR_HALT <= 1'b0;
    end else if (go_ee) begin
      PASS_THRU <= 1'b1;
      EE_POWER <= 1'b1;
      MONITOR_HALT <= 1'b1;
    end else if (PASS_THRU && ADDR_SEEN && ADDR_BYTE == maker_cmd_pkg::BATTERY_ADDR) begin
      // Host must leave the EEPROM its write time first
      PASS_THRU <= 1'b0;
      EE_POWER <= 1'b0;
      MONITOR_HALT <= 1'b0;
    end
  end

  // Alarm conditions; zero threshold disables, silent while monitoring is halted
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      LOW_CHARGE_WARN <= 1'b0;
      LOW_TIME_WARN <= 1'b0;
    end else begin
      LOW_CHARGE_WARN <= !MONITOR_HALT && charge_thr_ff != THR_ZERO && CHARGE_LEFT < charge_thr_ff;
      LOW_TIME_WARN <= !MONITOR_HALT && time_thr_ff != THR_ZERO && MEAN_TIME_LEFT < time_thr_ff;
    end
  end
endmodule : maker_command_and_alarm_thresholds

/* File: dv/smbus_host_model.sv */
`timescale 1ns/1ps
module smbus_host_model (
  // Clock and read answer
  input wire logic CLK,
  input wire logic RD_VALID,
  input wire logic [15:0] RD_DATA,
  // Word request
  output logic REQ_VALID,
  output logic REQ_WRITE,
  output logic [7:0] REQ_REG,
  output logic [15:0] REQ_WDATA,
  // Address byte seen on the bus
  output logic ADDR_SEEN,
  output logic [7:0] ADDR_BYTE
);
  initial begin
    REQ_VALID = 1'h0;
    REQ_WRITE = 1'h0;
    REQ_REG = 8'h00;
    REQ_WDATA = 16'h0000;
    ADDR_SEEN = 1'h0;
    ADDR_BYTE = 8'h00;
  end

  // Word writes only, one word per request
  task automatic wr(input logic [7:0] r, input logic [15:0] d);
    @(posedge CLK);
    #1;
    REQ_VALID = 1'h1;
    REQ_WRITE = 1'h1;
    REQ_REG = r;
    REQ_WDATA = d;
    @(posedge CLK);
    #1;
    REQ_VALID = 1'h0;
    REQ_WDATA = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] r, output logic [15:0] d);
    d = 16'hXXXX;
    @(posedge CLK);
    #1;
    REQ_VALID = 1'h1;
    REQ_WRITE = 1'h0;
    REQ_REG = r;
    @(posedge CLK);
    #1;
    REQ_VALID = 1'h0;
    for (int n = 0; n < 3 && RD_VALID !== 1'h1; n++) begin
      @(posedge CLK);
      #1;
    end
    if (RD_VALID === 1'h1) begin
      d = RD_DATA;
    end
  endtask : rd

  // Idle byte is inverted so a stale value never matches
  task automatic addr(input logic [7:0] b);
    @(posedge CLK);
    #1;
    ADDR_SEEN = 1'h1;
    ADDR_BYTE = b;
    @(posedge CLK);
    #1;
    ADDR_SEEN = 1'h0;
    ADDR_BYTE = ~b;
  endtask : addr
endmodule : smbus_host_model

/* File: dv/maker_cmd_monitor.sv */
`timescale 1ns/1ps
module maker_cmd_monitor #(
  parameter int TICK_CYCLES = 4,
  parameter int BOOT_IGNORE_MS = 3
) (
  // Clock, reset, requests
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [7:0] REQ_REG,
  input wire logic [15:0] REQ_WDATA,
  input wire logic ADDR_SEEN,
  input wire logic [7:0] ADDR_BYTE,
  input wire logic EE_SAVE_DONE,
  input wire logic [15:0] FULL_CAPACITY,
  input wire logic [7:0] TERM_PCT,
  // Watched outputs
  input wire logic EE_SAVE_REQ,
  input wire logic CHARGE_SYNC_STB,
  input wire logic [15:0] CHARGE_SYNC_VALUE,
  input wire logic SEALED,
  input wire logic LED_BLANK,
  input wire logic CAL_ACTIVE,
  input wire logic OFFSET_CORR_EN,
  input wire logic OFFSET_CAL_FLAG,
  input wire logic PASS_THRU,
  input wire logic EE_POWER,
  input wire logic MONITOR_HALT,
  input wire logic LOW_CHARGE_WARN,
  input wire logic LOW_TIME_WARN
);
  int unsigned up_cnt_ff;
  logic boot_done;
  logic [31:0] sync_exp;

  // Margin of two ticks so tick phase never matters
  assign boot_done = up_cnt_ff > (BOOT_IGNORE_MS + 2) * TICK_CYCLES;
  assign sync_exp = 32'(FULL_CAPACITY) * 32'(TERM_PCT) / 32'(maker_cmd_pkg::PCT_FULL);

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      up_cnt_ff <= '0;
    end else if (!boot_done) begin
      up_cnt_ff <= up_cnt_ff + 1;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  sequence s_cmd(logic [15:0] c);
    boot_done && REQ_VALID && REQ_WRITE && REQ_REG == maker_cmd_pkg::REG_CMD && REQ_WDATA == c;
  endsequence

  chk_seal_taken: assert property (s_cmd(maker_cmd_pkg::CODE_SEAL) |-> ##[1:2] SEALED)
    else $error("seal command not taken");
  chk_sync_pulse: assert property (s_cmd(maker_cmd_pkg::CODE_CHARGE_SYNC) && !LED_BLANK
    |=> CHARGE_SYNC_STB ##1 !CHARGE_SYNC_STB) else $error("sync strobe not one cycle");
  chk_sync_value: assert property (CHARGE_SYNC_STB |-> CHARGE_SYNC_VALUE == sync_exp[15:0])
    else $error("sync value wrong");
  chk_cal_reject: assert property (CAL_ACTIVE ##0 s_cmd(maker_cmd_pkg::CODE_CHARGE_SYNC)
    |=> !CHARGE_SYNC_STB [*2]) else $error("command taken during calibration");
  chk_cal_leds: assert property (CAL_ACTIVE |-> LED_BLANK) else $error("display on in calibration");
  chk_stop_cal: assert property (CAL_ACTIVE ##0 s_cmd(maker_cmd_pkg::CODE_CAL_STOP)
    |-> ##[1:2] (!CAL_ACTIVE && !OFFSET_CORR_EN)) else $error("stop did not abort");
  chk_flag_start: assert property ($rose(CAL_ACTIVE) |-> ##[0:1] !OFFSET_CAL_FLAG)
    else $error("flag kept at calibration start");
  chk_save_done: assert property (EE_SAVE_REQ && EE_SAVE_DONE
    |-> ##[1:2] (OFFSET_CAL_FLAG && OFFSET_CORR_EN && !EE_SAVE_REQ)) else $error("save end wrong");
  chk_pass_power: assert property (PASS_THRU |-> EE_POWER && MONITOR_HALT)
    else $error("pass-through without power or halt");
  chk_halt_quiet: assert property (MONITOR_HALT |=> !LOW_CHARGE_WARN && !LOW_TIME_WARN)
    else $error("warning while halted");
  chk_pass_exit: assert property (PASS_THRU && ADDR_SEEN && ADDR_BYTE == maker_cmd_pkg::BATTERY_ADDR
    |-> ##[1:2] !PASS_THRU) else $error("pass-through not ended");
endmodule : maker_cmd_monitor

bind maker_command_and_alarm_thresholds maker_cmd_monitor #(.TICK_CYCLES(TICK_CYCLES),
  .BOOT_IGNORE_MS(BOOT_IGNORE_MS)) mon (.*);

/* File: dv/maker_command_and_alarm_thresholds_tb.sv */
`timescale 1ns/1ps
module maker_command_and_alarm_thresholds_tb;
  localparam int T = 4;
  logic CLK = 1'h0;
  logic RSTN = 1'h0;
  logic REQ_VALID, REQ_WRITE, ADDR_SEEN, RD_VALID, EE_SAVE_REQ, CHARGE_SYNC_STB;
  logic [7:0] REQ_REG, ADDR_BYTE, TERM_PCT;
  logic [15:0] REQ_WDATA, RD_DATA, CHARGE_SYNC_VALUE;
  logic EE_LOAD_VALID = 1'h0;
  logic EE_SAVE_DONE = 1'h0;
  logic OFFSET_FOUND = 1'h0;
  logic [15:0] EE_CHARGE_THR, EE_TIME_THR, CHARGE_LEFT, MEAN_TIME_LEFT, FULL_CAPACITY;
  logic STORAGE_MODE, SEALED, LED_BLANK, SENSE_DISCONNECT, CAL_ACTIVE, OFFSET_CORR_EN;
  logic OFFSET_CAL_FLAG, PASS_THRU, EE_POWER, MONITOR_HALT, LOW_CHARGE_WARN, LOW_TIME_WARN;
  int fails = 0;
  int cmp_count = 0;
  logic [15:0] thr_tab [4] = '{16'h0000, 16'h0100, 16'h0101, 16'hFFFF};
  logic exp_tab [4] = '{1'h0, 1'h0, 1'h1, 1'h1};

  always #25 CLK = ~CLK;

  // Short counts keep the run brief
  maker_command_and_alarm_thresholds #(.TICK_CYCLES(T), .BOOT_IGNORE_MS(3), .STORE_DELAY_MS(5),
    .STORE_AFTER_CAL_MS(6), .CAL_START_MS(2), .CAL_CAP_MS(20)) dut (.*);
  smbus_host_model host (.*);

  task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic chk_bit(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic rd_chk(input logic [7:0] r, input logic [15:0] e);
    logic [15:0] d;
    host.rd(r, d);
    chk_word("register read", e, d);
  endtask : rd_chk

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : cyc

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  initial begin
    #400000;
    fails++;
    final_report();
  end

  initial begin
    EE_CHARGE_THR = 16'h0100;
    EE_TIME_THR = 16'h001E;
    CHARGE_LEFT = 16'h0100;
    MEAN_TIME_LEFT = 16'h0100;
    FULL_CAPACITY = 16'h03E8;
    TERM_PCT = 8'h5A;
    cyc(12);
    RSTN = 1'h1;
    host.wr(maker_cmd_pkg::REG_CMD, maker_cmd_pkg::CODE_SEAL);
    cyc(2);
    chk_bit("sealed", 1'h0, SEALED);
    EE_LOAD_VALID = 1'h1;
    cyc(1);
    EE_LOAD_VALID = 1'h0;
    rd_chk(maker_cmd_pkg::REG_CHARGE_THR, 16'h0100);
    rd_chk(maker_cmd_pkg::REG_TIME_THR, 16'h001E);
    rd_chk(8'h05, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      host.wr(maker_cmd_pkg::REG_CHARGE_THR, thr_tab[i]);
      host.wr(maker_cmd_pkg::REG_TIME_THR, thr_tab[i]);
      rd_chk(maker_cmd_pkg::REG_CHARGE_THR, thr_tab[i]);
      rd_chk(maker_cmd_pkg::REG_TIME_THR, thr_tab[i]);
      chk_bit("low charge", exp_tab[i], LOW_CHARGE_WARN);
      chk_bit("low time", exp_tab[i], LOW_TIME_WARN);
    end
    CHARGE_LEFT = 16'hFFFF;
    cyc(2);
    chk_bit("low charge", 1'h0, LOW_CHARGE_WARN);
    CHARGE_LEFT = 16'h0100;
    cyc(6 * T);
    host.wr(maker_cmd_pkg::REG_CMD, 16'h1234);
    rd_chk(maker_cmd_pkg::REG_CMD, 16'h1234);
    chk_bit("sealed", 1'h0, SEALED);
    host.wr(maker_cmd_pkg::REG_CMD, maker_cmd_pkg::CODE_CHARGE_SYNC);
    chk_bit("sync strobe", 1'h1, CHARGE_SYNC_STB);
    chk_word("sync value", 16'h0384, CHARGE_SYNC_VALUE);
    cyc(2 * T);
    rd_chk(maker_cmd_pkg::REG_CMD, 16'h0000);
    host.wr(maker_cmd_pkg::REG_CMD, maker_cmd_pkg::CODE_CAL_ALT);
    cyc(3 * T + 2);
    chk_bit("cal active", 1'h1, CAL_ACTIVE);
    chk_bit("sense off", 1'h0, SENSE_DISCONNECT);
    chk_bit("display blank", 1'h1, LED_BLANK);
    rd_chk(maker_cmd_pkg::REG_CMD, 16'h0000);
    OFFSET_FOUND = 1'h1;
    cyc(1);
    OFFSET_FOUND = 1'h0;
    cyc(1);
    chk_bit("save request", 1'h1, EE_SAVE_REQ);
    EE_SAVE_DONE = 1'h1;
    cyc(1);
    EE_SAVE_DONE = 1'h0;
    cyc(2);
    chk_bit("cal flag", 1'h1, OFFSET_CAL_FLAG);
    // Second run starts with the flag set, so its clearing shows
    host.wr(maker_cmd_pkg::REG_CMD, maker_cmd_pkg::CODE_CAL_ALT);
    cyc(3 * T + 2);
    chk_bit("cal flag", 1'h0, OFFSET_CAL_FLAG);
    chk_bit("cal active", 1'h1, CAL_ACTIVE);
    host.wr(maker_cmd_pkg::REG_CMD, maker_cmd_pkg::CODE_CAL_STOP);
    cyc(2);
    chk_bit("cal active", 1'h0, CAL_ACTIVE);
    chk_bit("offset corr", 1'h0, OFFSET_CORR_EN);
    host.wr(maker_cmd_pkg::REG_CMD, maker_cmd_pkg::CODE_EE_PROG);
    cyc(2);
    chk_bit("pass through", 1'h1, PASS_THRU);
    chk_bit("ee power", 1'h1, EE_POWER);
    chk_bit("low charge", 1'h0, LOW_CHARGE_WARN);
    host.addr(8'h10);
    cyc(2);
    chk_bit("pass through", 1'h1, PASS_THRU);
    cyc(10 * T);
    host.addr(maker_cmd_pkg::BATTERY_ADDR);
    cyc(2);
    chk_bit("pass through", 1'h0, PASS_THRU);
    host.wr(maker_cmd_pkg::REG_CMD, maker_cmd_pkg::CODE_STORAGE);
    cyc(2 * T);
    rd_chk(maker_cmd_pkg::REG_CMD, 16'h0000);
    host.wr(maker_cmd_pkg::REG_CMD, maker_cmd_pkg::CODE_CAL_STD);
    cyc(3 * T);
    chk_bit("cal active", 1'h1, CAL_ACTIVE);
    chk_bit("sense off", 1'h1, SENSE_DISCONNECT);
    chk_bit("cal flag", 1'h0, OFFSET_CAL_FLAG);
    host.wr(maker_cmd_pkg::REG_CMD, maker_cmd_pkg::CODE_CHARGE_SYNC);
    chk_bit("sync strobe", 1'h0, CHARGE_SYNC_STB);
    host.wr(maker_cmd_pkg::REG_CMD, maker_cmd_pkg::CODE_SEAL);
    cyc(6 * T);
    chk_bit("sealed", 1'h1, SEALED);
    rd_chk(maker_cmd_pkg::REG_CMD, 16'h0000);
    chk_bit("storage", 1'h0, STORAGE_MODE);
    OFFSET_FOUND = 1'h1;
    cyc(1);
    OFFSET_FOUND = 1'h0;
    cyc(1);
    chk_bit("save request", 1'h1, EE_SAVE_REQ);
    EE_SAVE_DONE = 1'h1;
    cyc(1);
    EE_SAVE_DONE = 1'h0;
    cyc(2);
    chk_bit("cal flag", 1'h1, OFFSET_CAL_FLAG);
    chk_bit("cal active", 1'h0, CAL_ACTIVE);
    cyc(3 * T);
    chk_bit("storage", 1'h0, STORAGE_MODE);
    cyc(5 * T);
    chk_bit("storage", 1'h1, STORAGE_MODE);
    chk_bit("display blank", 1'h0, LED_BLANK);
    host.wr(maker_cmd_pkg::REG_CMD, maker_cmd_pkg::CODE_CAL_STD);
    cyc(3 * T);
    chk_bit("cal active", 1'h0, CAL_ACTIVE);
    final_report();
  end
endmodule : maker_command_and_alarm_thresholds_tb
